// ### design/flash_host.sv
`include "flash_host_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module flash_host (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       cmd_valid,
  output logic                            cmd_ready,
  input  wire flash_host_pkg::cmd_t       cmd,
  output logic                            rsp_valid,
  output logic [7:0]                      rsp_data,
  input  wire logic                       pd_req,
  input  wire logic                       vpp_req,
  output flash_host_pkg::flash_pins_t     pins,
  input  wire logic [7:0]                 dq_in,
  input  wire logic                       ready_busy_out,
  output logic                            powerdown_reset_n,
  output logic                            program_supply_high
);
  import flash_host_pkg::*;

  localparam logic [5:0] STROBE = 6'(`FH_STROBE_CYC);
  localparam logic [5:0] LAST   = 6'(`FH_STROBE_CYC + 1);

  state_t      state;
  state_t      next_state;
  state_t      pin_state;
  cmd_t        cur;
  logic [5:0]  cnt;
  logic        pd_active;
  flash_pins_t next_pins;
  logic        bus_state;
  logic        is_read;
  logic        step_done;
  logic        alter_op;

  assign bus_state = (state == S_WR_A) || (state == S_WR_B) || (state == S_WR_ST)
                     || (state == S_WR_RA) || (state == S_RD);
  assign is_read   = (state == S_RD);
  assign step_done = bus_state && (cnt == LAST);
  assign alter_op  = (cur.op == OP_BYTE_WRITE) || (cur.op == OP_BLOCK_ERASE);
  assign cmd_ready = (state == S_IDLE) && !pd_active && !pd_req;

  // Sequence steps
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (!pd_active && !pd_req && cmd_valid) begin
          next_state = (cmd.op == OP_READ) ? S_RD : S_WR_A;
        end else if (pd_active && !pd_req) begin
          next_state = S_WAKE;
        end
      end
      S_WR_A: begin
        if (step_done) begin
          case (cur.op)
            // RULE17 second cycle
            OP_BYTE_WRITE, OP_BLOCK_ERASE: next_state = S_WR_B;
            OP_READ_ID, OP_READ_STATUS:    next_state = S_RD;
            OP_SUSPEND:                    next_state = S_WAIT;
            default:                       next_state = S_IDLE;
          endcase
        end
      end
      S_WR_B: begin
        if (step_done) begin
          next_state = S_WAIT;
        end
      end
      S_WAIT: begin
        if (cnt >= 6'(`FH_BUSY_LAT_CYC) && ready_busy_out) begin
          next_state = S_WR_ST;
        end
      end
      S_WR_ST: begin
        if (step_done) begin
          next_state = S_RD;
        end
      end
      S_RD: begin
        if (step_done) begin
          // RULE9 back to array
          next_state = alter_op ? S_WR_RA : S_IDLE;
        end
      end
      S_WR_RA: begin
        if (step_done) begin
          next_state = S_IDLE;
        end
      end
      S_WAKE: begin
        if (cnt == 6'(`FH_WAKE_CYC - 1)) begin
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Step cycle counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 6'h00;
    end else if (next_state != state) begin
      cnt <= 6'h00;
    end else if (state == S_WAIT && cnt >= 6'(`FH_BUSY_LAT_CYC)) begin
      cnt <= cnt;
    end else if (state != S_IDLE) begin
      cnt <= cnt + 6'h01;
    end
  end

  // Latched request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '0;
    end else if (cmd_valid && cmd_ready) begin
      cur <= cmd;
    end
  end

  // Powerdown and supply
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pd_active           <= 1'b0;
      powerdown_reset_n   <= 1'b0;
      program_supply_high <= 1'b0;
    end else begin
      program_supply_high <= vpp_req;
      if (state == S_IDLE && pd_req) begin
        pd_active <= 1'b1;
      end else if (state == S_WAKE) begin
        pd_active <= 1'b0;
      end
      powerdown_reset_n <= !((state == S_IDLE) && pd_req) && !(pd_active && state == S_IDLE);
    end
  end

  // Pin drive per step
  always_comb begin
    next_pins         = '0;
    next_pins.ce_b    = 1'b1;
    next_pins.oe_b    = 1'b1;
    next_pins.we_b    = 1'b1;
    next_pins.dq_oe_b = 1'b1;
    next_pins.addr    = cur.addr;
    if (bus_state && cnt != LAST) begin
      next_pins.ce_b    = 1'b0;
      next_pins.dq_oe_b = is_read;
      // RULE5 write strobe
      if (cnt >= 6'h01 && cnt <= STROBE) begin
        next_pins.we_b = is_read;
        next_pins.oe_b = !is_read;
      end
    end
    case (state)
      S_WR_A: begin
        case (cur.op)
          // RULE20 identifier mode
          OP_READ_ID:     next_pins.dq_out = `FH_CMD_READ_ID;
          OP_READ_STATUS: next_pins.dq_out = `FH_CMD_READ_STATUS;
          // RULE12 erase setup
          OP_BLOCK_ERASE: next_pins.dq_out = `FH_CMD_ERASE_SETUP;
          OP_BYTE_WRITE:  next_pins.dq_out = `FH_CMD_BYTE_WRITE;
          OP_SUSPEND:     next_pins.dq_out = `FH_CMD_SUSPEND;
          OP_RESUME:      next_pins.dq_out = `FH_CMD_RESUME;
          OP_CLEAR:       next_pins.dq_out = `FH_CMD_CLEAR_STATUS;
          default:        next_pins.dq_out = `FH_CMD_READ_ARRAY;
        endcase
      end
      // RULE14 address and data
      S_WR_B:  next_pins.dq_out = (cur.op == OP_BLOCK_ERASE) ? `FH_CMD_ERASE_CONF : cur.data;
      S_WR_ST: next_pins.dq_out = `FH_CMD_READ_STATUS;
      S_WR_RA: next_pins.dq_out = `FH_CMD_READ_ARRAY;
      default: next_pins.dq_out = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pins         <= '0;
      pins.ce_b    <= 1'b1;
      pins.oe_b    <= 1'b1;
      pins.we_b    <= 1'b1;
      pins.dq_oe_b <= 1'b1;
      pin_state    <= S_IDLE;
    end else begin
      pins      <= next_pins;
      pin_state <= state;
    end
  end

  // Answer to requester
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
    end else begin
      rsp_valid <= (state != S_IDLE) && (next_state == S_IDLE) && (state != S_WAKE);
      if (is_read && cnt == LAST) begin
        rsp_data <= dq_in;
      end
    end
  end

  chk_write_chip_select: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
    !pins.we_b |-> !pins.ce_b && pins.oe_b && !pins.dq_oe_b)
    else $error("write strobe without chip select or with output enable");

  chk_strobe_width: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
    $fell(pins.we_b) |-> (!pins.we_b)[*2] ##1 pins.we_b)
    else $error("write strobe width wrong");

  chk_two_cycle_seq: assert property (@(posedge clk) disable iff (!rst_b) // RULE17
    $rose(state == S_WR_B) |-> $past(state == S_WR_A) && alter_op)
    else $error("second command cycle without first");

  chk_erase_confirm: assert property (@(posedge clk) disable iff (!rst_b) // RULE12
    !pins.we_b && pin_state == S_WR_B && cur.op == OP_BLOCK_ERASE
    |-> pins.dq_out == `FH_CMD_ERASE_CONF)
    else $error("erase confirm code wrong");

  chk_write_payload: assert property (@(posedge clk) disable iff (!rst_b) // RULE14
    !pins.we_b && pin_state == S_WR_B && cur.op == OP_BYTE_WRITE
    |-> pins.dq_out == cur.data && pins.addr == cur.addr)
    else $error("byte write address or data wrong");

  chk_array_after_alter: assert property (@(posedge clk) disable iff (!rst_b) // RULE9
    state == S_RD && step_done && alter_op |=> state == S_WR_RA ##[1:20] pins.we_b == 1'b0
    && pins.dq_out == `FH_CMD_READ_ARRAY)
    else $error("read array not issued after alteration");

  chk_id_code: assert property (@(posedge clk) disable iff (!rst_b) // RULE20
    !pins.we_b && pin_state == S_WR_A && cur.op == OP_READ_ID |-> pins.dq_out == `FH_CMD_READ_ID)
    else $error("identifier command code wrong");

  chk_no_access_pd: assert property (@(posedge clk) disable iff (!rst_b) // RULE16
    !powerdown_reset_n |-> pins.ce_b && pins.we_b)
    else $error("bus access during powerdown");

endmodule : flash_host

`default_nettype wire

// ### include/flash_host_cfg.svh
// What this block does
// RULE1: Device reads array after power-up or powerdown exit until another command.
// RULE2: Device picks read, standby, output-disabled from control pin levels.
// RULE3: Status and identifier reads work with program supply low.
// RULE4: Erase and write succeed only with program supply high.
// RULE5: Host issues commands as plain write cycles, chip select and strobe low.
// RULE6: Device command register steers its internal write engine.
// RULE7: Each command write latches address and data inside the device.
// RULE8: Last mode command picks read source: array, identifier or status.
// RULE9: After write or erase, host issues read array before array reads.
// RULE10: Device lets software suspend erase, read other blocks, then resume; any command while suspended keeps the model in status mode.
// RULE11: Array is sixteen 64K-byte blocks, 00000 to FFFFF.
// RULE12: Erase starts only after erase setup then erase confirm.
// RULE13: Device reports progress in status and on the ready/busy pin.
// RULE14: Byte write starts only after host gives address and data.
// RULE15: Device engine repeats pulses and verifies data without the host.
// RULE16: Device is disabled while powerdown pin low or supply under lockout.
// RULE17: Write and erase each take a two-cycle command sequence.
// RULE18: Ready/busy low while engine runs, high when idle, suspended, powered down.
// RULE19: Powerdown exit resets to read array, upper status bits to 10000.
// RULE20: Code 90H selects identifier mode; reads at 00000H and 00001H.
// RULE21: Wrong confirm cycle starts nothing and flags a sequence error.
// RULE22: Alteration with program supply low leaves array and flags supply error.
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

`define FH_ADDR_W         20
`define FH_CNT_W          6
`define FH_CLK_NS         25
`define FH_STROBE_NS      50
`define FH_STROBE_CYC     ((`FH_STROBE_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_BUSY_LAT_NS    100
`define FH_BUSY_LAT_CYC   ((`FH_BUSY_LAT_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_WAKE_NS        1000
`define FH_WAKE_CYC       ((`FH_WAKE_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)

`define FH_CMD_READ_ARRAY   8'hff
`define FH_CMD_READ_ID      8'h90
`define FH_CMD_READ_STATUS  8'h70
`define FH_CMD_ERASE_SETUP  8'h20
`define FH_CMD_ERASE_CONF   8'hd0
`define FH_CMD_BYTE_WRITE   8'h40
`define FH_CMD_SUSPEND      8'hb0
`define FH_CMD_RESUME       8'hd0
`define FH_CMD_CLEAR_STATUS 8'h50

`endif

// ### include/flash_host_pkg.sv
package flash_host_pkg;

  typedef enum logic [3:0] {
    OP_READ_ARRAY  = 4'h0,
    OP_READ_ID     = 4'h1,
    OP_READ_STATUS = 4'h2,
    OP_READ        = 4'h3,
    OP_BYTE_WRITE  = 4'h4,
    OP_BLOCK_ERASE = 4'h5,
    OP_SUSPEND     = 4'h6,
    OP_RESUME      = 4'h7,
    OP_CLEAR       = 4'h8
  } op_t;

  typedef struct packed {
    op_t         op;
    logic [19:0] addr;
    logic [7:0]  data;
  } cmd_t;

  typedef enum logic [7:0] {
    S_IDLE  = 8'h01,
    S_WR_A  = 8'h02,
    S_WR_B  = 8'h04,
    S_WAIT  = 8'h08,
    S_WR_ST = 8'h10,
    S_RD    = 8'h20,
    S_WR_RA = 8'h40,
    S_WAKE  = 8'h80
  } state_t;

  typedef struct packed {
    logic        ce_b;
    logic        oe_b;
    logic        we_b;
    logic [19:0] addr;
    logic [7:0]  dq_out;
    logic        dq_oe_b;
  } flash_pins_t;

endpackage : flash_host_pkg

// ### tb/flash_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model #(
  parameter int         BUSY_CYC = 12,
  // Identity values are arbitrary
  parameter logic [7:0] MAKER_ID = 8'h5a,
  parameter logic [7:0] PART_ID  = 8'hc3
) (
  input  wire logic                        clk,
  input  wire flash_host_pkg::flash_pins_t pins,
  input  wire logic                        powerdown_reset_n,
  input  wire logic                        program_supply_high,
  output logic [7:0]                       dq_in,
  output logic                             ready_busy_out
);
  import flash_host_pkg::*;
  logic [7:0]  mem [logic [19:0]];
  logic [7:0]  sr = 8'h80, rd_val = 8'h00, last = 8'h00, wd, c;
  logic [1:0]  mode = 2'd0, pend = 2'd0;
  logic [19:0] wa;
  logic        we_q = 1'b1, ce_q = 1'b1, erase = 1'b0, susp = 1'b0;
  int          busy = 0;
  initial ready_busy_out = 1'b1;
  assign dq_in = (!pins.ce_b && !pins.oe_b && pins.we_b && powerdown_reset_n) ? rd_val : ~last;
  always @(posedge clk) begin
    we_q <= pins.we_b;
    ce_q <= pins.ce_b;
    last <= dq_in;
    if (!powerdown_reset_n) begin
      mode = 2'd0;
      pend = 2'd0;
      busy = 0;
      susp = 1'b0;
      sr = {5'b10000, sr[2:0]};
    end else if (busy > 0 && !susp) begin
      busy = busy - 1;
      if (busy == 0) begin
        if (!program_supply_high) sr = sr | (erase ? 8'ha8 : 8'h98);
        else if (erase) foreach (mem[k]) begin
          if (k[19:16] == wa[19:16]) mem[k] = 8'hff;
        end
        else mem[wa] = (mem.exists(wa) ? mem[wa] : 8'hff) & wd;
        sr[7] = 1'b1;
      end
    end
    // Write ends on strobe rise, select may rise with it
    if (powerdown_reset_n && pins.we_b && !we_q && !ce_q) begin
      c = pins.dq_out;
      if (pend != 2'd0) begin
        if (pend == 2'd1 || c == 8'hd0) begin
          erase = (pend == 2'd2);
          wa = pins.addr;
          wd = c;
          busy = BUSY_CYC;
          sr[7] = 1'b0;
        end else sr[5:4] = 2'b11;
        pend = 2'd0;
        mode = 2'd2;
      end else if (busy > 0) begin
        susp = (c == 8'hb0) ? 1'b1 : (c == 8'hd0) ? 1'b0 : susp;
        sr[7:6] = {susp, susp};
        mode = 2'd2;
      end else case (c)
        8'hff: mode = 2'd0;
        8'h90: mode = 2'd1;
        8'h70: mode = 2'd2;
        8'h50: sr[5:3] = 3'b000;
        8'h40: pend = 2'd1;
        8'h20: pend = 2'd2;
        default: ;
      endcase
    end
    rd_val <= (mode == 2'd2) ? sr : (mode == 2'd1) ? (pins.addr[0] ? PART_ID : MAKER_ID)
            : (mem.exists(pins.addr) ? mem[pins.addr] : 8'hff);
    ready_busy_out <= !(busy > 0 && !susp) || !powerdown_reset_n;
  end
endmodule : flash_dev_model
`default_nettype wire

// ### tb/flash_host_tb.sv
`timescale 1ns/10ps
`default_nettype none
module flash_host_tb;
  import flash_host_pkg::*;
  localparam logic [7:0] MAKER_ID = 8'h5a;
  localparam logic [7:0] PART_ID  = 8'hc3;
  logic        clk = 1'b0, rst_b = 1'b0, cmd_valid = 1'b0, pd_req = 1'b0, vpp_req = 1'b0;
  logic        cmd_ready, rsp_valid, ready_busy_out, powerdown_reset_n, program_supply_high;
  logic        saw_busy;
  logic [7:0]  rsp_data, dq_in, got;
  cmd_t        cmd = '0;
  flash_pins_t pins;
  int          num_errors = 0, check_count = 0, cycles = 0, wait_n;
  always #12.5 clk = ~clk;
  flash_host dut (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pd_req(pd_req), .vpp_req(vpp_req),
    .pins(pins), .dq_in(dq_in), .ready_busy_out(ready_busy_out),
    .powerdown_reset_n(powerdown_reset_n), .program_supply_high(program_supply_high));
  flash_dev_model #(.BUSY_CYC(12), .MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) model (
    .clk(clk), .pins(pins), .powerdown_reset_n(powerdown_reset_n),
    .program_supply_high(program_supply_high), .dq_in(dq_in), .ready_busy_out(ready_busy_out));
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic check8(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check8
  task automatic run_op(input op_t o, input logic [19:0] a, input logic [7:0] d);
    @(negedge clk);
    cmd = '{o, a, d};
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    wait_n = 0;
    saw_busy = 1'b0;
    while (rsp_valid !== 1'b1 && wait_n < 2000) begin
      @(negedge clk);
      wait_n++;
      if (ready_busy_out === 1'b0) saw_busy = 1'b1;
    end
    if (rsp_valid !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    end
    got = rsp_data;
  endtask : run_op
  task automatic t_ident();
    run_op(OP_READ, 20'h12345, 8'h00);
    check8(got, 8'hff);
    run_op(OP_READ_ID, 20'h00000, 8'h00);
    check8(got, MAKER_ID);
    run_op(OP_READ_ID, 20'h00001, 8'h00);
    check8(got, PART_ID);
    run_op(OP_READ_STATUS, 20'h00000, 8'h00);
    check8(got, 8'h80);
  endtask : t_ident
  task automatic t_write();
    vpp_req = 1'b1;
    run_op(OP_BYTE_WRITE, 20'h0fffe, 8'ha5);
    check8(got, 8'h80);
    check8({7'h0, saw_busy}, 8'h01);
    check8({7'h0, program_supply_high}, 8'h01);
    run_op(OP_BYTE_WRITE, 20'h10000, 8'h3c);
    run_op(OP_READ, 20'h0fffe, 8'h00);
    check8(got, 8'ha5);
    run_op(OP_READ, 20'h10000, 8'h00);
    check8(got, 8'h3c);
  endtask : t_write
  task automatic t_erase();
    run_op(OP_BLOCK_ERASE, 20'h1abcd, 8'h00);
    check8(got, 8'h80);
    run_op(OP_SUSPEND, 20'h1abcd, 8'h00);
    check8(got, 8'h80);
    run_op(OP_RESUME, 20'h1abcd, 8'h00);
    run_op(OP_READ_ARRAY, 20'h00000, 8'h00);
    run_op(OP_READ, 20'h10000, 8'h00);
    check8(got, 8'hff);
    run_op(OP_READ, 20'h0fffe, 8'h00);
    check8(got, 8'ha5);
  endtask : t_erase
  task automatic t_low_vpp();
    vpp_req = 1'b0;
    run_op(OP_BYTE_WRITE, 20'h0fffe, 8'h00);
    check8(got, 8'h98);
    check8({7'h0, program_supply_high}, 8'h00);
    run_op(OP_READ, 20'h0fffe, 8'h00);
    check8(got, 8'ha5);
    run_op(OP_CLEAR, 20'h00000, 8'h00);
    run_op(OP_READ_STATUS, 20'h00000, 8'h00);
    check8(got, 8'h80);
    run_op(OP_BLOCK_ERASE, 20'h00000, 8'h00);
    check8(got, 8'ha8);
  endtask : t_low_vpp
  task automatic t_powerdown();
    run_op(OP_READ_STATUS, 20'h00000, 8'h00);
    check8(got, 8'ha8);
    pd_req = 1'b1;
    repeat (8) @(negedge clk);
    check8({7'h0, powerdown_reset_n}, 8'h00);
    check8({7'h0, cmd_ready}, 8'h00);
    pd_req = 1'b0;
    run_op(OP_READ, 20'h0fffe, 8'h00);
    check8(got, 8'ha5);
    run_op(OP_READ_STATUS, 20'h00000, 8'h00);
    check8(got, 8'h80);
  endtask : t_powerdown
  initial begin
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    t_ident();
    t_write();
    t_erase();
    t_low_vpp();
    t_powerdown();
    tally_and_finish();
  end
endmodule : flash_host_tb
`default_nettype wire
